/* rtl/imp_pkg.sv */
package imp_pkg;
    // ****************************************
    // register addresses on the internal bus
    // ****************************************
    localparam logic [7:0] ADDR_ENABLE_PRIMARY = 8'hA8;
    localparam logic [7:0] ADDR_LEVEL_PRIMARY = 8'hB8;
    localparam logic [7:0] ADDR_EXT_ENABLE_ONE = 8'hE6;
    localparam logic [7:0] ADDR_EXT_ENABLE_TWO = 8'hE7;
    localparam logic [7:0] ADDR_EXT_LEVEL_ONE = 8'hF6;
    localparam logic [7:0] ADDR_EXT_LEVEL_TWO = 8'hF7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RESET_REG = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_GLOBAL_GATE = 7;
    localparam int BIT_SPARE_USER_FLAG = 6;
    localparam int BIT_TIMER2 = 5;
    localparam int BIT_UART = 4;
    localparam int BIT_TIMER1 = 3;
    localparam int BIT_EXT1 = 2;
    localparam int BIT_TIMER0 = 1;
    localparam int BIT_EXT0 = 0;
    localparam int BIT_TWO_RESERVED = 6;
    localparam logic [7:0] LEVEL_PRIMARY_UNUSED = 8'hC0;
    localparam logic [7:0] TWO_WRITABLE = 8'hBF;

    // number of request sources: 6 primary + 8 ext one + 7 ext two
    localparam int NUM_SOURCES = 21;

    // source index layout in the flat source vector
    localparam int SRC_PRIMARY_LO = 0;
    localparam int SRC_ONE_LO = 6;
    localparam int SRC_TWO_LO = 14;
endpackage

/* rtl/imp_level_or.sv */
// ****************************************
// per-level request reduction
// ****************************************
module imp_level_or
    import imp_pkg::*;
#(
    parameter int WIDTH = NUM_SOURCES
)
(
    input wire logic [WIDTH-1:0] pending,
    input wire logic [WIDTH-1:0] mask,
    input wire logic [WIDTH-1:0] level,
    input wire logic gate,
    output logic req_high,
    output logic req_low
);
    // refused at elaboration: an empty source vector has nothing to reduce
    if (WIDTH < 1)
    begin
        $error("imp_level_or: WIDTH must be at least 1");
    end

    always_comb
    begin
        req_high = gate && |(pending & mask & level);
        req_low = gate && |(pending & mask & ~level);
    end
endmodule

/* rtl/imp_mask_level_regs.sv */
// Function
// - Global gate low blocks every request; high lets each mask decide.
// - Spare user flag is read/write and affects nothing.
// - Timer 2, 1, 0 masks pass their overflow flags only when set.
// - UART mask passes receive-done or transmit-done flag, one shared source.
// - External 0 and 1 masks pass active-low pin requests only when set.
// - First extended enable holds comparator edge masks in bits 7 to 4.
// - First extended enable bits 3-0: counter array, window, two-wire, serial periph.
// - Second extended enable bits 5 to 2 mask external interrupts 7 to 4.
// - Bit 6 of both second extended registers reads 0; software writes 0.
// - Primary level register upper two bits read 11b, writes ignored.
// - Level bit 0 is low, 1 is high; primary map matches enable map.
// - First extended level register matches first extended enable positions.
// - Second extended level register matches second extended enable positions.
// - Reset places every source at low level; all-zero levels are default.
// - Pending flags set regardless of masks; masking only suppresses requests.
// - High request may preempt low service; high service is never preempted.
module imp_mask_level_regs
    import imp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WRITE,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_READ,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    input wire logic TIMER0_OVERFLOW_FLAG,
    input wire logic TIMER1_OVERFLOW_FLAG,
    input wire logic TIMER2_OVERFLOW_FLAG,
    input wire logic TIMER3_OVERFLOW_FLAG,
    input wire logic UART_RX_DONE_FLAG,
    input wire logic UART_TX_DONE_FLAG,
    input wire logic EXT0_PIN_N,
    input wire logic EXT1_PIN_N,
    input wire logic [3:0] EXT_HIGH_PENDING,
    input wire logic [3:0] CMP_EDGE_PENDING,
    input wire logic COUNTER_ARRAY_PENDING,
    input wire logic WINDOW_COMPARE_PENDING,
    input wire logic TWOWIRE_PENDING,
    input wire logic SERIAL_PERIPH_PENDING,
    input wire logic XTAL_STABLE_FLAG,
    input wire logic CONV_DONE_PENDING,
    input wire logic IN_SERVICE_HIGH,
    input wire logic IN_SERVICE_LOW,
    output logic REQ_HIGH,
    output logic REQ_LOW,
    output logic [NUM_SOURCES-1:0] REQ_SOURCES
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] enable_primary;
        logic [5:0] level_primary;
        logic [7:0] ext_enable_one;
        logic [7:0] ext_enable_two;
        logic [7:0] ext_level_one;
        logic [7:0] ext_level_two;
        logic [1:0] ext_pin_sync0;
        logic [1:0] ext_pin_sync1;
        logic [7:0] rdata;
        logic hit;
        logic req_high;
        logic req_low;
        logic [NUM_SOURCES-1:0] req_sources;
    } imp_state_s;

    imp_state_s state;
    imp_state_s next_state;

    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] mask;
    logic [NUM_SOURCES-1:0] level;
    logic gate;
    logic level_high;
    logic level_low;

    // ****************************************
    // source vectors
    // ****************************************
    // pins pass two flops; active-low pins become active-high pending
    always_comb
    begin
        pending = '0;
        pending[SRC_PRIMARY_LO + BIT_EXT0] = ~state.ext_pin_sync1[0];
        pending[SRC_PRIMARY_LO + BIT_TIMER0] = TIMER0_OVERFLOW_FLAG;
        pending[SRC_PRIMARY_LO + BIT_EXT1] = ~state.ext_pin_sync1[1];
        pending[SRC_PRIMARY_LO + BIT_TIMER1] = TIMER1_OVERFLOW_FLAG;
        // both uart flags share one source
        pending[SRC_PRIMARY_LO + BIT_UART] = UART_RX_DONE_FLAG | UART_TX_DONE_FLAG;
        pending[SRC_PRIMARY_LO + BIT_TIMER2] = TIMER2_OVERFLOW_FLAG;
        pending[SRC_ONE_LO + 0] = SERIAL_PERIPH_PENDING;
        pending[SRC_ONE_LO + 1] = TWOWIRE_PENDING;
        pending[SRC_ONE_LO + 2] = WINDOW_COMPARE_PENDING;
        pending[SRC_ONE_LO + 3] = COUNTER_ARRAY_PENDING;
        // order cmp0 fall, cmp0 rise, cmp1 fall, cmp1 rise
        pending[SRC_ONE_LO + 7 -: 4] = CMP_EDGE_PENDING;
        pending[SRC_TWO_LO + 0] = TIMER3_OVERFLOW_FLAG;
        pending[SRC_TWO_LO + 1] = CONV_DONE_PENDING;
        pending[SRC_TWO_LO + 5 -: 4] = EXT_HIGH_PENDING;
        pending[SRC_TWO_LO + 6] = XTAL_STABLE_FLAG;
    end

    // pending flags are taken as-is; masking touches only requests
    always_comb
    begin
        gate = state.enable_primary[BIT_GLOBAL_GATE];
        // spare flag bit 6 is deliberately left out of the mask vector
        mask = {state.ext_enable_two[7], state.ext_enable_two[5:0],
                state.ext_enable_one, state.enable_primary[5:0]};
        level = {state.ext_level_two[7], state.ext_level_two[5:0],
                 state.ext_level_one, state.level_primary};
    end

    imp_level_or #(
        .WIDTH(NUM_SOURCES)
    ) u_level_or (
        .pending(pending),
        .mask(mask),
        .level(level),
        .gate(gate),
        .req_high(level_high),
        .req_low(level_low)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_state.ext_pin_sync0 = {EXT1_PIN_N, EXT0_PIN_N};
        next_state.ext_pin_sync1 = state.ext_pin_sync0;

        // writes land at the edge, so requests use them the cycle after
        if (SFR_WRITE)
        begin
            case (SFR_ADDR)
                ADDR_ENABLE_PRIMARY: next_state.enable_primary = SFR_WDATA;
                ADDR_LEVEL_PRIMARY: next_state.level_primary = SFR_WDATA[5:0];
                ADDR_EXT_ENABLE_ONE: next_state.ext_enable_one = SFR_WDATA;
                ADDR_EXT_ENABLE_TWO: next_state.ext_enable_two = SFR_WDATA & TWO_WRITABLE;
                ADDR_EXT_LEVEL_ONE: next_state.ext_level_one = SFR_WDATA;
                ADDR_EXT_LEVEL_TWO: next_state.ext_level_two = SFR_WDATA & TWO_WRITABLE;
                default: next_state.hit = state.hit;
            endcase
        end

        next_state.hit = SFR_READ || SFR_WRITE ?
            (SFR_ADDR == ADDR_ENABLE_PRIMARY || SFR_ADDR == ADDR_LEVEL_PRIMARY ||
             SFR_ADDR == ADDR_EXT_ENABLE_ONE || SFR_ADDR == ADDR_EXT_ENABLE_TWO ||
             SFR_ADDR == ADDR_EXT_LEVEL_ONE || SFR_ADDR == ADDR_EXT_LEVEL_TWO) : 1'b0;

        // read data registered: ready one cycle after the read strobe
        next_state.rdata = 8'h00;
        if (SFR_READ)
        begin
            case (SFR_ADDR)
                ADDR_ENABLE_PRIMARY: next_state.rdata = state.enable_primary;
                ADDR_LEVEL_PRIMARY: next_state.rdata = LEVEL_PRIMARY_UNUSED
                    | {2'b00, state.level_primary};
                ADDR_EXT_ENABLE_ONE: next_state.rdata = state.ext_enable_one;
                ADDR_EXT_ENABLE_TWO: next_state.rdata = state.ext_enable_two
                    & TWO_WRITABLE;
                ADDR_EXT_LEVEL_ONE: next_state.rdata = state.ext_level_one;
                ADDR_EXT_LEVEL_TWO: next_state.rdata = state.ext_level_two
                    & TWO_WRITABLE;
                default: next_state.rdata = 8'h00;
            endcase
        end

        // a high service blocks both requests; a low service lets only high through
        next_state.req_high = level_high && !IN_SERVICE_HIGH;
        next_state.req_low = level_low && !IN_SERVICE_HIGH && !IN_SERVICE_LOW;
        next_state.req_sources = gate ? (pending & mask) : '0;

        if (RESET)
        begin
            next_state = '0;
            next_state.enable_primary = RESET_REG;
            next_state.level_primary = RESET_REG[5:0];
            next_state.ext_level_one = RESET_REG;
            next_state.ext_level_two = RESET_REG;
            next_state.ext_enable_one = RESET_REG;
            next_state.ext_enable_two = RESET_REG;
            // pins idle high so no false request after reset
            next_state.ext_pin_sync0 = 2'b11;
            next_state.ext_pin_sync1 = 2'b11;
        end
    end

    always_ff @(posedge CLK)
    begin
        state <= next_state;
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb
    begin
        SFR_RDATA = state.rdata;
        SFR_HIT = state.hit;
        REQ_HIGH = state.req_high;
        REQ_LOW = state.req_low;
        REQ_SOURCES = state.req_sources;
    end
endmodule

/* tb/imp_partner.sv */
// ********
// peripheral pending sources, source-ordered vector in
// ********
module imp_partner
(
    input wire logic [20:0] pend,
    input wire logic alt,
    output logic EXT0_PIN_N,
    output logic EXT1_PIN_N,
    output logic TIMER0_OVERFLOW_FLAG,
    output logic TIMER1_OVERFLOW_FLAG,
    output logic TIMER2_OVERFLOW_FLAG,
    output logic TIMER3_OVERFLOW_FLAG,
    output logic UART_RX_DONE_FLAG,
    output logic UART_TX_DONE_FLAG,
    output logic [3:0] EXT_HIGH_PENDING,
    output logic [3:0] CMP_EDGE_PENDING,
    output logic COUNTER_ARRAY_PENDING,
    output logic WINDOW_COMPARE_PENDING,
    output logic TWOWIRE_PENDING,
    output logic SERIAL_PERIPH_PENDING,
    output logic XTAL_STABLE_FLAG,
    output logic CONV_DONE_PENDING
);
    // flags follow their source alone, masks never reach back here
    assign EXT0_PIN_N = ~pend[0];
    assign TIMER0_OVERFLOW_FLAG = pend[1];
    assign EXT1_PIN_N = ~pend[2];
    assign TIMER1_OVERFLOW_FLAG = pend[3];
    // only one uart flag at a time, so each is seen alone
    assign UART_RX_DONE_FLAG = pend[4] & alt;
    assign UART_TX_DONE_FLAG = pend[4] & ~alt;
    assign TIMER2_OVERFLOW_FLAG = pend[5];
    assign {CMP_EDGE_PENDING, COUNTER_ARRAY_PENDING, WINDOW_COMPARE_PENDING} = pend[13:8];
    assign {TWOWIRE_PENDING, SERIAL_PERIPH_PENDING} = pend[7:6];
    assign {EXT_HIGH_PENDING, CONV_DONE_PENDING, TIMER3_OVERFLOW_FLAG} = pend[19:14];
    assign XTAL_STABLE_FLAG = pend[20];
endmodule

/* tb/imp_checker.sv */
module imp_checker
    import imp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WRITE,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_READ,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_HIT,
    input wire logic IN_SERVICE_HIGH,
    input wire logic IN_SERVICE_LOW,
    input wire logic REQ_HIGH,
    input wire logic REQ_LOW,
    input wire logic [NUM_SOURCES-1:0] REQ_SOURCES
);
    // ********
    // helper state and properties
    // ********
    logic gate;
    logic mapped;
    assign mapped = SFR_ADDR inside {ADDR_ENABLE_PRIMARY, ADDR_LEVEL_PRIMARY,
        ADDR_EXT_ENABLE_ONE, ADDR_EXT_ENABLE_TWO, ADDR_EXT_LEVEL_ONE, ADDR_EXT_LEVEL_TWO};
    always_ff @(posedge CLK)
    begin
        if (RESET)
            gate <= 1'b0;
        else if (SFR_WRITE && SFR_ADDR == ADDR_ENABLE_PRIMARY)
            gate <= SFR_WDATA[BIT_GLOBAL_GATE];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_hit_mapped: assert property ((SFR_READ || SFR_WRITE) && mapped |=> SFR_HIT)
        else $error("missing hit on mapped access");
    a_unmapped_silent: assert property (SFR_READ && !mapped |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("unmapped read answered");
    a_idle_quiet: assert property (!SFR_READ |=> SFR_RDATA == 8'h00)
        else $error("read data without read");
    a_level_upper_ones: assert property (SFR_READ && SFR_ADDR == ADDR_LEVEL_PRIMARY |=> SFR_RDATA[7:6] == 2'b11)
        else $error("level upper bits not ones");
    a_reserved_zero: assert property (SFR_READ && mapped && SFR_ADDR[3:0] == 4'h7 |=> !SFR_RDATA[6])
        else $error("reserved bit reads one");
    a_gate_blocks: assert property (!gate |=> REQ_SOURCES == '0)
        else $error("request with gate closed");
    a_high_held_off: assert property (IN_SERVICE_HIGH |=> !REQ_HIGH && !REQ_LOW)
        else $error("request during high service");
    a_low_held_off: assert property (IN_SERVICE_LOW |=> !REQ_LOW)
        else $error("low request during low service");
    a_req_has_source: assert property (REQ_HIGH || REQ_LOW |-> REQ_SOURCES != '0)
        else $error("request without source");
endmodule
bind imp_mask_level_regs imp_checker u_chk (.CLK, .RESET, .SFR_ADDR, .SFR_WRITE, .SFR_WDATA,
    .SFR_READ, .SFR_RDATA, .SFR_HIT, .IN_SERVICE_HIGH, .IN_SERVICE_LOW, .REQ_HIGH, .REQ_LOW, .REQ_SOURCES);

/* tb/tb.sv */
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb
    import imp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 0, RESET = 1, SFR_WRITE = 0, SFR_READ = 0, IN_SERVICE_HIGH = 0, IN_SERVICE_LOW = 0;
    logic alt = 0, SFR_HIT, REQ_HIGH, REQ_LOW, EXT0_PIN_N, EXT1_PIN_N, XTAL_STABLE_FLAG;
    logic TIMER0_OVERFLOW_FLAG, TIMER1_OVERFLOW_FLAG, TIMER2_OVERFLOW_FLAG, TIMER3_OVERFLOW_FLAG;
    logic UART_RX_DONE_FLAG, UART_TX_DONE_FLAG, COUNTER_ARRAY_PENDING, WINDOW_COMPARE_PENDING;
    logic TWOWIRE_PENDING, SERIAL_PERIPH_PENDING, CONV_DONE_PENDING;
    logic [3:0] EXT_HIGH_PENDING, CMP_EDGE_PENDING;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, regs [6];
    logic [7:0] addr [6] = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7};
    logic [20:0] pend = '0;
    logic [NUM_SOURCES-1:0] REQ_SOURCES;
    int mismatches = 0, checks_done = 0;
    integer seed = 32'had87;
    imp_mask_level_regs u_dut (.*);
    imp_partner u_src (.*);
    initial forever #2.5 CLK = ~CLK;
    // ********
    // expectation helpers and bus tasks
    // ********
    function automatic logic [20:0] vec(input logic [7:0] p, o, t);
        return {t[7], t[5:0], o, p[5:0]};
    endfunction
    function automatic logic [7:0] rb(input int i, input logic [7:0] v);
        return (i == 1) ? (v | 8'hC0) : ((i == 3 || i == 5) ? (v & 8'hBF) : v);
    endfunction
    task bus(input logic w, input logic [7:0] a, d, exp_rd, input logic hit);
        @(negedge CLK);
        {SFR_WRITE, SFR_READ, SFR_ADDR, SFR_WDATA} = {w, !w, a, d};
        @(negedge CLK);
        {SFR_WRITE, SFR_READ} = 2'b00;
        `CHK(SFR_HIT, hit)
        if (!w) `CHK(SFR_RDATA, exp_rd)
    endtask
    task run(input logic [20:0] p, input logic a, input logic [1:0] svc);
        logic [20:0] s, l;
        // software keeps reserved bit 6 of both second registers at zero
        regs[3] = regs[3] & 8'hBF;
        regs[5] = regs[5] & 8'hBF;
        for (int i = 0; i < 6; i++) bus(1, addr[i], regs[i], 0, 1);
        {pend, alt, IN_SERVICE_HIGH, IN_SERVICE_LOW} = {p, a, svc};
        // pins need two sync stages plus the request stage
        repeat (4) @(negedge CLK);
        s = regs[0][7] ? (p & vec(regs[0], regs[2], regs[3])) : '0;
        l = vec(regs[1], regs[4], regs[5]);
        `CHK(REQ_SOURCES, s)
        `CHK(REQ_HIGH, |(s & l) & !svc[1])
        `CHK(REQ_LOW, |(s & ~l) & !svc[1] & !svc[0])
        for (int i = 0; i < 6; i++) bus(0, addr[i], 0, rb(i, regs[i]), 1);
        $display("scenario done at %0t", $time);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge CLK);
        RESET = 0;
        for (int i = 0; i < 6; i++) bus(0, addr[i], 0, rb(i, 8'h00), 1);
        bus(0, 8'hA9, 0, 0, 0);
        bus(1, 8'h00, 8'hFF, 0, 0);
        $display("reset values done at %0t", $time);
        regs = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        run('1, 1, 2'b00);
        regs = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
        run('1, 0, 2'b00);
        regs = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        run('1, 1, 2'b10);
        run(21'h000004, 0, 2'b01);
        for (int n = 0; n < 40; n++)
        begin
            foreach (regs[i]) regs[i] = $random(seed);
            run($random(seed), $random(seed), $random(seed));
        end
        // second reset in mid-run must bring every register back to zero
        RESET = 1;
        repeat (2) @(negedge CLK);
        RESET = 0;
        for (int i = 0; i < 6; i++) bus(0, addr[i], 0, rb(i, 8'h00), 1);
        $display("mid-run reset done at %0t", $time);
        give_verdict;
    end
    // whole run is well under 2000 cycles
    initial
    begin
        #25000;
        mismatches++;
        give_verdict;
    end
endmodule
